/* File: logic/rtc_irq_status_alarm_ext.sv */
/*
  Status and alarm-extension part of a real-time clock: option bits,
  read-to-clear interrupt flags with one active-low request, validity
  bit, relocatable day, month and century registers, power-supply
  control outputs. APB slave on a single 10 MHz clock.
  Assumes divider taps, update and match inputs from the clock unit
  arrive asynchronously and are held long enough to be synchronised.
*/
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module rtc_irq_status_alarm_ext
  import rtc_status_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic masterReset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [14:0] divTap,
  input wire logic updateEnded,
  input wire logic timeMatch,
  input wire logic [5:0] dayNow,
  input wire logic [5:0] monthNow,
  input wire logic lowSupply,
  input wire logic oscRunning,
  input wire logic switchOff,
  input wire logic powerOffEvent,
  output logic irqN,
  output logic freezeUpdates,
  output logic [3:0] rateSelect,
  output logic [2:0] dividerControl,
  output logic binaryFormat,
  output logic hour24Mode,
  output logic daylightSave,
  output logic supplyOnControl,
  output logic powerOffRequest,
  output logic sciRequest,
  output logic ledDrive
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] rateSel;
    logic [2:0] divCtl;
    logic freeze;
    logic periodicIrqEnable;
    logic alarmIrqEnable;
    logic updateDoneIrqEnable;
    logic binarySel;
    logic hour24;
    logic daylight;
    logic updateDoneFlag;
    logic alarmFlag;
    logic periodicFlag;
    logic irqActive;
    logic powerValid;
    logic [7:0] century;
    logic [7:0] dayAlarm;
    logic [7:0] monthAlarm;
    logic [7:0] dayLoc;
    logic [7:0] monthLoc;
    logic [7:0] centuryLoc;
    logic supplyOn;
    logic led;
    logic sciEnable;
    logic offReq;
    logic sciActive;
    logic [9:0] swGap;
    logic [9:0] offGap;
    logic [14:0] tapS1;
    logic [14:0] tapS2;
    logic tapPrev;
    logic [1:0] updS;
    logic updPrev;
    logic [1:0] matchS;
    logic [5:0] dayS1;
    logic [5:0] dayS2;
    logic [5:0] monS1;
    logic [5:0] monS2;
    logic [1:0] lowS;
    logic [1:0] oscS;
    logic [1:0] swS;
    logic swPrev;
    logic [1:0] offS;
    logic offPrev;
    logic [1:0] mrS;
    logic rdy;
    logic err;
    logic [31:0] rdData;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [1:0] rstSync_q;
  logic rstInt_n;

  // Alarm field match with the don't-care code
  function automatic logic fieldMatch(input logic [7:0] alarm, input logic [5:0] now);
    fieldMatch = (alarm[7:6] == DONT_CARE) || (alarm[5:0] == now);
  endfunction

  // Hold-off counter for one event type
  function automatic logic [9:0] gapNext(input logic [9:0] cnt, input logic take);
    if (take) begin
      gapNext = EVT_GAP_CYC;
    end else if (cnt != 10'h000) begin
      gapNext = cnt - 10'h001;
    end else begin
      gapNext = cnt;
    end
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Async assert, two-flop release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstInt_n = rstSync_q[1];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  reg_sel_t sel;
  logic [7:0] loc;
  logic done;
  logic wr;
  logic rd;
  logic tapSel;
  logic tapEdge;
  logic updEvt;
  logic alarmEvt;
  logic oscOn;
  logic swEvt;
  logic offEvt;
  logic mr;
  logic [7:0] rdByte;

  always_comb begin
    s_d = s_q;
    loc = {paddr[BANK_BIT], paddr[8:2]};
    done = psel && penable && s_q.rdy;
    wr = done && pwrite;
    rd = done && !pwrite;
    rdByte = 8'h00;

    // Synchronisers
    s_d.tapS1 = divTap;
    s_d.tapS2 = s_q.tapS1;
    s_d.updS = {s_q.updS[0], updateEnded};
    s_d.matchS = {s_q.matchS[0], timeMatch};
    s_d.dayS1 = dayNow;
    s_d.dayS2 = s_q.dayS1;
    s_d.monS1 = monthNow;
    s_d.monS2 = s_q.monS1;
    s_d.lowS = {s_q.lowS[0], lowSupply};
    s_d.oscS = {s_q.oscS[0], oscRunning};
    s_d.swS = {s_q.swS[0], switchOff};
    s_d.offS = {s_q.offS[0], powerOffEvent};
    s_d.mrS = {s_q.mrS[0], masterReset};
    mr = s_q.mrS[1];
    oscOn = s_q.oscS[1];

    // Event detection
    tapSel = (s_q.rateSel == 4'h0) ? 1'b0 : s_q.tapS2[s_q.rateSel - 4'h1];
    s_d.tapPrev = tapSel;
    tapEdge = tapSel && !s_q.tapPrev;
    s_d.updPrev = s_q.updS[1];
    updEvt = s_q.updS[1] && !s_q.updPrev;
    alarmEvt = updEvt && s_q.matchS[1] && fieldMatch(s_q.dayAlarm, s_q.dayS2)
      && fieldMatch(s_q.monthAlarm, s_q.monS2);
    s_d.swPrev = s_q.swS[1];
    s_d.offPrev = s_q.offS[1];
    swEvt = oscOn && s_q.swS[1] && !s_q.swPrev && (s_q.swGap == 10'h000);
    offEvt = oscOn && s_q.offS[1] && !s_q.offPrev && (s_q.offGap == 10'h000);
    s_d.swGap = gapNext(s_q.swGap, swEvt);
    s_d.offGap = gapNext(s_q.offGap, offEvt);

    // Address decode; moved registers answer only at their locator
    if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
      sel = SEL_NONE;
    end else if (paddr[8:2] == IDX_RATE) begin
      sel = SEL_RATE;
    end else if (paddr[8:2] == IDX_OPTIONS) begin
      sel = SEL_OPTIONS;
    end else if (paddr[8:2] == IDX_FLAGS) begin
      sel = SEL_FLAGS;
    end else if (paddr[8:2] == IDX_VALIDITY) begin
      sel = SEL_VALIDITY;
    end else if (loc == {1'b1, IDX_DAY_LOC}) begin
      sel = SEL_DAY_LOC;
    end else if (loc == {1'b1, IDX_MONTH_LOC}) begin
      sel = SEL_MONTH_LOC;
    end else if (loc == {1'b1, IDX_CENTURY_LOC}) begin
      sel = SEL_CENTURY_LOC;
    end else if (loc == s_q.dayLoc) begin
      sel = SEL_DAY_ALARM;
    end else if (loc == s_q.monthLoc) begin
      sel = SEL_MONTH_ALARM;
    end else if (loc == s_q.centuryLoc) begin
      sel = SEL_CENTURY;
    end else if (loc == {1'b1, IDX_POWER_CTRL}) begin
      sel = SEL_POWER_CTRL;
    end else if (loc == {1'b1, IDX_POWER_STAT}) begin
      sel = SEL_POWER_STAT;
    end else begin
      sel = SEL_NONE;
    end

    // Read value of the selected register
    case (sel)
      SEL_RATE: rdByte = {1'b0, s_q.divCtl, s_q.rateSel};
      SEL_OPTIONS: rdByte = {s_q.freeze, s_q.periodicIrqEnable, s_q.alarmIrqEnable,
        s_q.updateDoneIrqEnable, 1'b0, s_q.binarySel, s_q.hour24, s_q.daylight};
      SEL_FLAGS: rdByte = {s_q.irqActive, s_q.periodicFlag, s_q.alarmFlag,
        s_q.updateDoneFlag, 4'h0};
      SEL_VALIDITY: rdByte = {s_q.powerValid, 7'h00};
      SEL_DAY_LOC: rdByte = s_q.dayLoc;
      SEL_MONTH_LOC: rdByte = s_q.monthLoc;
      SEL_CENTURY_LOC: rdByte = s_q.centuryLoc;
      SEL_DAY_ALARM: rdByte = s_q.dayAlarm;
      SEL_MONTH_ALARM: rdByte = s_q.monthAlarm;
      SEL_CENTURY: rdByte = s_q.century;
      SEL_POWER_CTRL: rdByte = {5'h00, s_q.sciEnable, s_q.led, s_q.supplyOn};
      SEL_POWER_STAT: rdByte = {7'h00, s_q.offReq};
      default: rdByte = 8'h00;
    endcase

    // Bus handshake: one wait cycle, data and error latched
    if (psel && penable && !s_q.rdy) begin
      s_d.rdy = 1'b1;
      s_d.rdData = {24'h000000, rdByte};
      s_d.err = (sel == SEL_NONE);
    end else begin
      s_d.rdy = 1'b0;
      s_d.err = 1'b0;
    end

    // Register writes
    if (wr) begin
      case (sel)
        SEL_RATE: begin
          s_d.rateSel = pwdata[3:0];
          s_d.divCtl = pwdata[6:4];
        end
        SEL_OPTIONS: begin
          s_d.freeze = pwdata[OPT_FREEZE];
          s_d.periodicIrqEnable = pwdata[OPT_PER_IE];
          s_d.alarmIrqEnable = pwdata[OPT_ALARM_IE];
          s_d.updateDoneIrqEnable = pwdata[OPT_UPD_IE];
          s_d.binarySel = pwdata[OPT_BINARY];
          s_d.hour24 = pwdata[OPT_HOUR24];
          s_d.daylight = pwdata[OPT_DST];
        end
        SEL_DAY_LOC: s_d.dayLoc = pwdata[7:0];
        SEL_MONTH_LOC: s_d.monthLoc = pwdata[7:0];
        SEL_CENTURY_LOC: s_d.centuryLoc = pwdata[7:0];
        SEL_DAY_ALARM: s_d.dayAlarm = pwdata[7:0];
        SEL_MONTH_ALARM: s_d.monthAlarm = pwdata[7:0];
        SEL_CENTURY: s_d.century = pwdata[7:0];
        SEL_POWER_CTRL: begin
          if (oscOn) begin
            s_d.supplyOn = pwdata[PWR_SUPPLY];
            s_d.led = pwdata[PWR_LED];
            s_d.sciEnable = pwdata[PWR_SCI_EN];
          end
        end
        default: s_d.rateSel = s_q.rateSel;
      endcase
    end

    // Flags: a read clears only what it reported; a new event wins
    if (rd && sel == SEL_FLAGS) begin
      s_d.updateDoneFlag = (s_q.updateDoneFlag && !s_q.rdData[FLG_UPDATE]) || updEvt;
      s_d.alarmFlag = (s_q.alarmFlag && !s_q.rdData[FLG_ALARM]) || alarmEvt;
      s_d.periodicFlag = (s_q.periodicFlag && !s_q.rdData[FLG_PERIODIC]) || tapEdge;
    end else begin
      s_d.updateDoneFlag = s_q.updateDoneFlag | updEvt;
      s_d.alarmFlag = s_q.alarmFlag | alarmEvt;
      s_d.periodicFlag = s_q.periodicFlag | tapEdge;
    end

    // Validity: read sets it, low supply clears it and wins
    if (s_q.lowS[1]) begin
      s_d.powerValid = 1'b0;
    end else if (rd && sel == SEL_VALIDITY) begin
      s_d.powerValid = 1'b1;
    end

    // Power-off request: event wins over status read clear
    if (rd && sel == SEL_POWER_STAT) begin
      s_d.offReq = (s_q.offReq && !s_q.rdData[PST_OFF_REQ]) || swEvt || offEvt;
    end else begin
      s_d.offReq = s_q.offReq || swEvt || offEvt;
    end

    // Master reset clears interrupt enables and flags only
    if (mr) begin
      s_d.periodicIrqEnable = 1'b0;
      s_d.alarmIrqEnable = 1'b0;
      s_d.updateDoneIrqEnable = 1'b0;
      s_d.updateDoneFlag = 1'b0;
      s_d.alarmFlag = 1'b0;
      s_d.periodicFlag = 1'b0;
    end

    // Request pairs
    s_d.irqActive = (s_d.periodicIrqEnable && s_d.periodicFlag)
      || (s_d.alarmIrqEnable && s_d.alarmFlag)
      || (s_d.updateDoneIrqEnable && s_d.updateDoneFlag);
    s_d.sciActive = s_d.sciEnable && (s_d.offReq || s_d.alarmFlag);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Power-on values; master reset acts in the next-state logic
  always_ff @(posedge clock or negedge rstInt_n) begin
    if (!rstInt_n) begin
      s_q <= '0;
      s_q.powerValid <= 1'b1;
      s_q.century <= CENTURY_INIT;
      s_q.dayAlarm <= ALARM_INIT;
      s_q.monthAlarm <= ALARM_INIT;
      s_q.dayLoc <= DAY_LOC_INIT;
      s_q.monthLoc <= MONTH_LOC_INIT;
      s_q.centuryLoc <= CENTURY_LOC_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = s_q.rdData;
  assign pready = s_q.rdy;
  assign pslverr = s_q.err;
  assign irqN = !s_q.irqActive;
  assign freezeUpdates = s_q.freeze;
  assign rateSelect = s_q.rateSel;
  assign dividerControl = s_q.divCtl;
  assign binaryFormat = s_q.binarySel;
  assign hour24Mode = s_q.hour24;
  assign daylightSave = s_q.daylight;
  assign supplyOnControl = s_q.supplyOn;
  assign powerOffRequest = s_q.offReq;
  assign sciRequest = s_q.sciActive;
  assign ledDrive = s_q.led;

endmodule

`default_nettype wire

/* File: logic/rtc_status_pkg.sv */
/*
  Constants for the clock status and alarm-extension block: register
  indexes, field positions, reset values and timing counts.
  Assumes a 10 MHz system clock and APB byte addresses of four times
  the register index, with bank one above bank zero.
*/
`default_nettype none

package rtc_status_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int EVT_GAP_NS = 70000;
  localparam int EVT_GAP_CYC_I = EVT_GAP_NS / CLK_PERIOD_NS;  // Rounds down
  localparam logic [9:0] EVT_GAP_CYC = EVT_GAP_CYC_I[9:0];

  // ----------------------------------------------------------------
  // Address layout
  // ----------------------------------------------------------------
  localparam int BANK_BIT = 9;
  localparam logic [6:0] IDX_RATE = 7'h0A;
  localparam logic [6:0] IDX_OPTIONS = 7'h0B;
  localparam logic [6:0] IDX_FLAGS = 7'h0C;
  localparam logic [6:0] IDX_VALIDITY = 7'h0D;
  localparam logic [6:0] IDX_POWER_CTRL = 7'h40;
  localparam logic [6:0] IDX_POWER_STAT = 7'h42;
  localparam logic [6:0] IDX_CENTURY = 7'h48;
  localparam logic [6:0] IDX_DAY_ALARM = 7'h49;
  localparam logic [6:0] IDX_MONTH_ALARM = 7'h4A;
  localparam logic [6:0] IDX_DAY_LOC = 7'h4F;
  localparam logic [6:0] IDX_MONTH_LOC = 7'h50;
  localparam logic [6:0] IDX_CENTURY_LOC = 7'h51;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OPT_DST = 0;
  localparam int OPT_HOUR24 = 1;
  localparam int OPT_BINARY = 2;
  localparam int OPT_UPD_IE = 4;
  localparam int OPT_ALARM_IE = 5;
  localparam int OPT_PER_IE = 6;
  localparam int OPT_FREEZE = 7;
  localparam int FLG_UPDATE = 4;
  localparam int FLG_ALARM = 5;
  localparam int FLG_PERIODIC = 6;
  localparam int FLG_REQUEST = 7;
  localparam int VAL_BIT = 7;
  localparam int PWR_SUPPLY = 0;
  localparam int PWR_LED = 1;
  localparam int PWR_SCI_EN = 2;
  localparam int PST_OFF_REQ = 0;

  // ----------------------------------------------------------------
  // Power-up values
  // ----------------------------------------------------------------
  localparam logic [7:0] CENTURY_INIT = 8'h00;
  localparam logic [7:0] ALARM_INIT = 8'hC0;
  localparam logic [1:0] DONT_CARE = 2'h3;
  localparam logic [7:0] DAY_LOC_INIT = 8'hC9;
  localparam logic [7:0] MONTH_LOC_INIT = 8'hCA;
  localparam logic [7:0] CENTURY_LOC_INIT = 8'hC8;

  // Register selected by the current bus address
  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_RATE = 4'h1,
    SEL_OPTIONS = 4'h2,
    SEL_FLAGS = 4'h3,
    SEL_VALIDITY = 4'h4,
    SEL_DAY_LOC = 4'h5,
    SEL_MONTH_LOC = 4'h6,
    SEL_CENTURY_LOC = 4'h7,
    SEL_DAY_ALARM = 4'h8,
    SEL_MONTH_ALARM = 4'h9,
    SEL_CENTURY = 4'hA,
    SEL_POWER_CTRL = 4'hB,
    SEL_POWER_STAT = 4'hC
  } reg_sel_t;

endpackage

`default_nettype wire

/* File: tb/rtc_irq_status_alarm_ext_properties.sv */
/* Port checker for the clock status block.
   Bound to the block; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none

module rtc_status_checker
  import rtc_status_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic masterReset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic lowSupply,
  input wire logic oscRunning,
  input wire logic irqN,
  input wire logic freezeUpdates,
  input wire logic [3:0] rateSelect,
  input wire logic supplyOnControl,
  input wire logic powerOffRequest
);
  localparam logic [11:0] RATE_A = {3'h0, IDX_RATE, 2'h0};
  localparam logic [11:0] OPT_A = {3'h0, IDX_OPTIONS, 2'h0};
  localparam logic [11:0] FLG_A = {3'h0, IDX_FLAGS, 2'h0};
  localparam logic [11:0] VAL_A = {3'h0, IDX_VALIDITY, 2'h0};
  localparam logic [11:0] PWR_A = {3'h1, IDX_POWER_CTRL, 2'h0};
  localparam logic [11:0] PST_A = {3'h1, IDX_POWER_STAT, 2'h0};
  logic done;
  logic readFlags;
  logic readValid;
  logic writePower;
  logic readStatus;

  // ------------------------------------------------------------
  // Completed transfer decode
  // ------------------------------------------------------------
  assign done = psel && penable && pready;
  assign readFlags = done && !pwrite && paddr == FLG_A;
  assign readValid = done && !pwrite && paddr == VAL_A;
  assign writePower = done && pwrite && paddr == PWR_A;
  assign readStatus = done && !pwrite && paddr == PST_A;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  chk_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_flag_zero: assert property (readFlags |-> prdata[3:0] == 4'h0)
    else $error("flag low bits not zero");
  chk_flag_request: assert property (readFlags && $stable(irqN) |-> prdata[7] == !irqN)
    else $error("request bit not inverse of irqN");
  chk_valid_zero: assert property (readValid |-> prdata[6:0] == 7'h00)
    else $error("validity low bits not zero");
  chk_valid_low: assert property (lowSupply [*6] ##0 readValid |-> !prdata[VAL_BIT])
    else $error("validity set while supply low");
  chk_mreset_irq: assert property (masterReset [*6] |-> irqN)
    else $error("irqN low during master reset");
  chk_error_data: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("data on refused access");
  chk_freeze_write: assert property (done && pwrite && paddr == OPT_A |=>
    freezeUpdates == $past(pwdata[OPT_FREEZE]))
    else $error("freeze bit not taken");
  chk_rate_write: assert property (done && pwrite && paddr == RATE_A |=>
    rateSelect == $past(pwdata[3:0]))
    else $error("rate field not taken");
  chk_power_hold: assert property (!oscRunning [*5] ##0 writePower |=> $stable(supplyOnControl))
    else $error("power control changed with oscillator stopped");
  chk_power_write: assert property (oscRunning [*5] ##0 writePower |=>
    supplyOnControl == $past(pwdata[PWR_SUPPLY]))
    else $error("supply control not taken");
  chk_request_clear: assert property ($fell(powerOffRequest) |-> $past(readStatus))
    else $error("power-off request dropped without read");
endmodule

bind rtc_irq_status_alarm_ext rtc_status_checker checker_i (
  .clock(clock), .rst_n(rst_n), .masterReset(masterReset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .lowSupply(lowSupply),
  .oscRunning(oscRunning), .irqN(irqN), .freezeUpdates(freezeUpdates),
  .rateSelect(rateSelect), .supplyOnControl(supplyOnControl),
  .powerOffRequest(powerOffRequest)
);

`default_nettype wire

/* File: tb/rtc_irq_status_alarm_ext_tb.sv */
/* Self-checking bench for the clock status block.
   Drives APB and the clock unit inputs itself. */
`timescale 1ns/10ps
`default_nettype none

module rtc_irq_status_alarm_ext_tb
  import rtc_status_pkg::*;
;
  localparam logic [11:0] RATE_A = 12'h028;
  localparam logic [11:0] OPT_A = 12'h02C;
  localparam logic [11:0] FLG_A = 12'h030;
  localparam logic [11:0] VAL_A = 12'h034;
  localparam logic [11:0] CEN_A = 12'h320;
  localparam logic [11:0] DAY_A = 12'h324;
  localparam logic [11:0] MON_A = 12'h328;
  localparam logic [11:0] PWR_A = 12'h300;
  localparam logic [11:0] PST_A = 12'h308;
  localparam int LIMIT = 5000;
  // Day alarm, day now, month alarm, month now, flags
  localparam logic [39:0] ALARMS [5] = '{40'h15_15_0C_0C_B0, 40'h15_16_0C_0C_10,
    40'hC0_07_0C_0C_B0, 40'h15_15_0C_0B_10, 40'h15_15_C5_0B_B0};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic masterReset = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [14:0] divTap = 15'h0000;
  logic updateEnded = 1'b0;
  logic timeMatch = 1'b0;
  logic [5:0] dayNow = 6'h00;
  logic [5:0] monthNow = 6'h00;
  logic lowSupply = 1'b0;
  logic oscRunning = 1'b1;
  logic switchOff = 1'b0;
  logic powerOffEvent = 1'b0;
  logic [31:0] prdata;
  logic [3:0] rateSelect;
  logic [2:0] dividerControl;
  logic binaryFormat, hour24Mode, daylightSave, ledDrive;
  logic pready, pslverr, irqN, freezeUpdates, supplyOnControl, powerOffRequest, sciRequest;
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  rtc_irq_status_alarm_ext DUT (
    .clock(clock), .rst_n(rst_n), .masterReset(masterReset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .divTap(divTap), .updateEnded(updateEnded),
    .timeMatch(timeMatch), .dayNow(dayNow), .monthNow(monthNow), .lowSupply(lowSupply),
    .oscRunning(oscRunning), .switchOff(switchOff), .powerOffEvent(powerOffEvent),
    .irqN(irqN), .freezeUpdates(freezeUpdates), .rateSelect(rateSelect),
    .dividerControl(dividerControl), .binaryFormat(binaryFormat),
    .hour24Mode(hour24Mode), .daylightSave(daylightSave),
    .supplyOnControl(supplyOnControl), .powerOffRequest(powerOffRequest),
    .sciRequest(sciRequest), .ledDrive(ledDrive)
  );

  // Clock and hang guard
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails = fails + 1;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, {24'h0, d}, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] q;
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
    check(q, {24'h0, exp});
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic e;
    tick(6);
    rst_n <= 1'b1;
    tick(3);
    rd(CEN_A, 8'h00);
    rd(DAY_A, 8'hC0);
    rd(MON_A, 8'hC0);
    rd(VAL_A, 8'h80);
    rd(FLG_A, 8'h00);
    rd(OPT_A, 8'h00);
    wr(CEN_A, 8'h21);
    rd(CEN_A, 8'h21);
    wr(RATE_A, 8'h26);
    check(32'(rateSelect), 32'h6);
    check(32'(dividerControl), 32'h2);
    // Periodic: unselected tap first, then the selected one
    wr(OPT_A, 8'h40);
    divTap <= 15'h0010;
    tick(10);
    rd(FLG_A, 8'h00);
    divTap <= 15'h0030;
    tick(10);
    check(32'(irqN), 32'h0);
    rd(FLG_A, 8'hC0);
    check(32'(irqN), 32'h1);
    rd(FLG_A, 8'h00);
    // Update-done event
    wr(OPT_A, 8'h10);
    updateEnded <= 1'b1;
    tick(10);
    check(32'(irqN), 32'h0);
    rd(FLG_A, 8'h90);
    updateEnded <= 1'b0;
    // Alarm match cases with don't-care codes
    wr(OPT_A, 8'h20);
    timeMatch <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(DAY_A, ALARMS[i][39:32]);
      wr(MON_A, ALARMS[i][23:16]);
      dayNow <= ALARMS[i][29:24];
      monthNow <= ALARMS[i][13:8];
      updateEnded <= 1'b1;
      tick(10);
      rd(FLG_A, ALARMS[i][7:0]);
      updateEnded <= 1'b0;
      tick(4);
    end
    // Master reset with a pending request
    wr(OPT_A, 8'hF7);
    updateEnded <= 1'b1;
    tick(10);
    masterReset <= 1'b1;
    tick(6);
    masterReset <= 1'b0;
    tick(4);
    check(32'(irqN), 32'h1);
    check(32'(freezeUpdates), 32'h1);
    rd(OPT_A, 8'h87);
    check(32'({binaryFormat, hour24Mode, daylightSave}), 32'h7);
    rd(FLG_A, 8'h00);
    rd(CEN_A, 8'h21);
    rd(MON_A, 8'hC5);
    updateEnded <= 1'b0;
    // Low supply, then read-to-set
    lowSupply <= 1'b1;
    tick(6);
    rd(VAL_A, 8'h00);
    lowSupply <= 1'b0;
    tick(4);
    rd(VAL_A, 8'h00);
    rd(VAL_A, 8'h80);
    // Move the day alarm to bank 0 index 10h
    wr(12'h33C, 8'h10);
    rd(12'h040, 8'h15);
    xfer(1'b0, DAY_A, 32'h0, q, e);
    check(32'(e), 32'h1);
    // Power control and event spacing
    wr(PWR_A, 8'h07);
    check(32'(supplyOnControl), 32'h1);
    check(32'(ledDrive), 32'h1);
    switchOff <= 1'b1;
    tick(8);
    check(32'(powerOffRequest), 32'h1);
    check(32'(sciRequest), 32'h1);
    rd(PST_A, 8'h01);
    switchOff <= 1'b0;
    tick(4);
    switchOff <= 1'b1;
    tick(8);
    check(32'(powerOffRequest), 32'h0);
    switchOff <= 1'b0;
    tick(700);
    switchOff <= 1'b1;
    tick(8);
    check(32'(powerOffRequest), 32'h1);
    rd(PST_A, 8'h01);
    oscRunning <= 1'b0;
    tick(6);
    wr(PWR_A, 8'h00);
    check(32'(supplyOnControl), 32'h1);
    check(32'(ledDrive), 32'h1);
    powerOffEvent <= 1'b1;
    tick(8);
    check(32'(powerOffRequest), 32'h0);
    oscRunning <= 1'b1;
    powerOffEvent <= 1'b0;
    tick(6);
    powerOffEvent <= 1'b1;
    tick(8);
    check(32'(powerOffRequest), 32'h1);
    stop_test();
  end
endmodule

`default_nettype wire
